// ### logic/exposure_quantizer.v
`timescale 1ns/1ps
`include "exposure_timing_defs.vh"

module exposure_quantizer
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Request
  input  wire        start,
  input  wire [39:0] dividend,
  input  wire [21:0] divisor,
  // Result
  output reg         done,
  output reg  [19:0] line_count
);

  reg        busy_q;
  reg [5:0]  cnt_q;
  reg [39:0] num_q;
  reg [22:0] rem_q;
  reg [21:0] div_q;
  reg [22:0] rem_sh;
  reg [22:0] rem_d;
  reg        bit_d;

  always @*
  begin
    rem_sh = {rem_q[21:0], num_q[39]};
    bit_d  = (rem_sh >= {1'b0, div_q});
    rem_d  = bit_d ? (rem_sh - {1'b0, div_q}) : rem_sh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restoring division, one quotient bit per clock, rounded up at the end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_q     <= 1'b0;
      cnt_q      <= 6'h00;
      num_q      <= 40'h00_0000_0000;
      rem_q      <= 23'h00_0000;
      div_q      <= 22'h00_0000;
      done       <= 1'b0;
      line_count <= 20'h0_0000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 6'h27;
        num_q  <= dividend;
        rem_q  <= 23'h00_0000;
        div_q  <= divisor;
      end
      else if (busy_q)
      begin
        num_q <= {num_q[38:0], bit_d};
        rem_q <= rem_d;
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h00)
        begin
          busy_q     <= 1'b0;
          done       <= 1'b1;
          line_count <= num_q[18:0] * 20'h0_0002 + {19'h0_0000, bit_d}
                        + {19'h0_0000, (rem_d != 23'h00_0000)}; // R7
        end
      end
    end
  end

endmodule

// ### logic/exposure_timing_defs.vh
`ifndef EXPOSURE_TIMING_DEFS_VH
`define EXPOSURE_TIMING_DEFS_VH

// Clock and line periods, in units of 10 ps
`define CLK_PERIOD_PS10      22'h00_09C4
`define LINE_STD_PS10        22'h0E_DE64
`define LINE_SLOW_PS10       22'h31_8FF8

// Exposure limits, in ns
`define EXP_MIN_STD_NS       33'h0_000F_4240
`define EXP_MIN_SLOW_NS      33'h0_002D_C6C0
`define EXP_MAX_STD_NS       33'h0_7735_9400
`define EXP_MAX_SLOW_NS      33'h1_65A0_BC00
`define SUB_MIN_STD_NS       17'h0_9830
`define SUB_MIN_SLOW_NS      17'h1_FBC6
`define SUB_MIN_REF_SHIFT    2

// Conversion of ns to 10 ps units
`define NS_TO_PS10           40'h00_0000_0064

// Frame overheads, in line periods
`define TRIG_EXTRA_LINES     21'h00_000A
`define SYNC_EXTRA_LINES     21'h00_0005

// Trigger modes
`define MODE_FREE            3'h0
`define MODE_EDGE            3'h1
`define MODE_LEVEL           3'h2
`define MODE_SYNC            3'h3
`define MODE_START           3'h4
`define MODE_GR_EDGE         3'h5
`define MODE_GR_LEVEL        3'h6

`endif

// ### logic/split_area_exposure_timing.v
// Function
// [R1] Slow scan line period 32.4812 us; free run frame is line count lines.
// [R2] Edge or level trigger frame is lines plus exposure plus ten lines.
// [R3] Synchronous readout trigger frame is line count plus five lines.
// [R4] Start trigger uses the free running frame period.
// [R5] Frame period ignores output pixel bit depth.
// [R6] Top and bottom halves keep separate exposure settings.
// [R7] Exposure rounds up to whole line periods of the current scan.
// [R8] Standard scan exposure accepted from 1 ms to 2 s.
// [R9] Slow scan exposure accepted from 3 ms to 6 s.
// [R10] Sub-array minimum exposure scales with sub-array lines, 4-line base.
// [R11] Free run sub-array below 1 ms or 3 ms shares one exposure.
// [R12] Shorter exposure starts later so both halves end together.
// [R13] Free run shutters shorter half; both if both below readout.
// [R14] Level, global reset level and sync readout share one exposure.
// [R15] Global exposure pulse follows longer or shorter half as selected.
// [R16] No global exposure pulse when both halves below readout time.
// [R17] Exposure kept in line counts; a line tick advances all timing.
`timescale 1ns/1ps
`include "exposure_timing_defs.vh"

module split_area_exposure_timing
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Configuration
  input  wire        slow_scan,
  input  wire [2:0]  trigger_mode,
  input  wire [10:0] vertical_line_count,
  input  wire        subarray_en,
  input  wire [10:0] subarray_lines,
  input  wire        gexp_follow_short,
  input  wire        run_en,
  // Exposure requests in ns
  input  wire        load,
  input  wire [32:0] requested_exposure_top,
  input  wire [32:0] requested_exposure_bot,
  // Trigger
  input  wire        trigger_in,
  // Status
  output reg         exposure_ready_q,
  output reg         exposure_clamped_q,
  output reg  [19:0] exposure_line_count_top_q,
  output reg  [19:0] exposure_line_count_bot_q,
  output reg  [20:0] frame_lines_q,
  // Timing outputs
  output reg         line_tick_q,
  output reg         readout_start_q,
  output reg         expose_top_q,
  output reg         expose_bot_q,
  output reg         shutter_top_q,
  output reg         shutter_bot_q,
  output reg         global_exposure_q
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RUN  = 2'b10;

  reg  [1:0]  state_q;
  reg         slow_q;
  reg         trig_prev_q;
  reg  [21:0] acc_q;
  reg  [20:0] lc_q;
  reg  [19:0] raw_top_q;
  reg  [19:0] raw_bot_q;
  reg         below_top_q;
  reg  [1:0]  done_seen_q;
  wire [1:0]  q_done;
  wire [19:0] q_count [0:1];

  ////////////////////////////////////////////////////////////////////////////
  // Request range check and conversion

  wire [21:0] line_ps10 = slow_scan ? `LINE_SLOW_PS10 : `LINE_STD_PS10;
  wire [21:0] line_run  = slow_q ? `LINE_SLOW_PS10 : `LINE_STD_PS10;
  wire [16:0] sub_base  = slow_scan ? `SUB_MIN_SLOW_NS : `SUB_MIN_STD_NS;
  wire [27:0] sub_prod  = {11'h000, sub_base} * {17'h0_0000, subarray_lines};
  wire [32:0] sub_min   = {7'h00, sub_prod[27:`SUB_MIN_REF_SHIFT]}; // R10
  wire [32:0] full_min  = slow_scan ? `EXP_MIN_SLOW_NS : `EXP_MIN_STD_NS;
  wire [32:0] exp_min   = subarray_en ? sub_min : full_min; // R8 R9
  wire [32:0] exp_max   = slow_scan ? `EXP_MAX_SLOW_NS : `EXP_MAX_STD_NS;
  wire [32:0] req [0:1];
  wire [32:0] clamped [0:1];
  wire [1:0]  clamp_hit;

  assign req[0] = requested_exposure_top; // R6
  assign req[1] = requested_exposure_bot;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : half
      assign clamped[g]   = (req[g] < exp_min) ? exp_min :
                            (req[g] > exp_max) ? exp_max : req[g];
      assign clamp_hit[g] = (req[g] < exp_min) || (req[g] > exp_max);
      exposure_quantizer quant
      (
        .clk        (clk),
        .reset      (reset),
        .start      (load),
        .dividend   ({7'h00, clamped[g]} * `NS_TO_PS10),
        .divisor    (line_ps10),
        .done       (q_done[g]),
        .line_count (q_count[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and shared-exposure selection

  wire m_free  = (trigger_mode == `MODE_FREE);
  wire m_start = (trigger_mode == `MODE_START);
  wire m_sync  = (trigger_mode == `MODE_SYNC);
  wire m_grst  = (trigger_mode == `MODE_GR_EDGE) ||
                 (trigger_mode == `MODE_GR_LEVEL);
  wire m_trig  = (trigger_mode == `MODE_EDGE) ||
                 (trigger_mode == `MODE_LEVEL) || m_grst;
  wire m_share = (trigger_mode == `MODE_LEVEL) ||
                 (trigger_mode == `MODE_GR_LEVEL) || m_sync; // R14
  wire sub_share = m_free && subarray_en && below_top_q; // R11
  wire share     = m_share || sub_share;

  wire [19:0] exp_top  = raw_top_q;
  wire [19:0] exp_bot  = share ? raw_top_q : raw_bot_q;
  wire [19:0] exp_long = (exp_top > exp_bot) ? exp_top : exp_bot;
  wire [20:0] vn       = {10'h000, vertical_line_count};
  wire        both_short = (exp_top < vn[19:0]) && (exp_bot < vn[19:0]);

  // Frame length in lines; no bit depth enters here
  reg [20:0] frame_len;
  reg [20:0] ro_at;
  always @*
  begin
    if (m_trig)
    begin
      frame_len = vn + {1'b0, exp_long} + `TRIG_EXTRA_LINES; // R2 R5
      ro_at     = {1'b0, exp_long};
    end
    else if (m_sync)
    begin
      frame_len = vn + `SYNC_EXTRA_LINES; // R3
      ro_at     = 21'h00_0000;
    end
    else
    begin
      frame_len = vn; // R1 R4
      ro_at     = vn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exposure windows: measured back from the common readout start, except the sync-mode idle window (idle_x)

  wire        run    = (state_q == S_RUN);
  wire [20:0] remain = ro_at - lc_q;
  wire        pre_ro = run && (lc_q < ro_at);
  wire        idle_x = (state_q == S_IDLE) && m_sync && run_en;
  wire [20:0] gx_top = m_grst ? {1'b0, exp_top} : ({1'b0, exp_top} - vn);
  wire [20:0] gx_bot = m_grst ? {1'b0, exp_bot} : ({1'b0, exp_bot} - vn);
  wire        g_top  = pre_ro && (m_grst || exp_top > vn[19:0]) &&
                       (remain <= gx_top);
  wire        g_bot  = pre_ro && (m_grst || exp_bot > vn[19:0]) &&
                       (remain <= gx_bot);
  wire        top_long = (exp_top >= exp_bot);
  wire        g_long   = top_long ? g_top : g_bot;
  wire        g_short  = top_long ? g_bot : g_top;
  wire        trig_rise = trigger_in && !trig_prev_q;
  wire        tick_d    = (acc_q + `CLK_PERIOD_PS10) >= line_run;
  wire        last_line = (lc_q >= frame_len - 21'h00_0001);

  ////////////////////////////////////////////////////////////////////////////
  // Line tick, exposure registers and frame sequencer

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q                   <= S_IDLE;
      slow_q                    <= 1'b0;
      trig_prev_q               <= 1'b0;
      acc_q                     <= 22'h00_0000;
      lc_q                      <= 21'h00_0000;
      raw_top_q                 <= 20'h0_0000;
      raw_bot_q                 <= 20'h0_0000;
      below_top_q               <= 1'b0;
      done_seen_q               <= 2'b00;
      exposure_ready_q          <= 1'b0;
      exposure_clamped_q        <= 1'b0;
      exposure_line_count_top_q <= 20'h0_0000;
      exposure_line_count_bot_q <= 20'h0_0000;
      frame_lines_q             <= 21'h00_0000;
      line_tick_q               <= 1'b0;
      readout_start_q           <= 1'b0;
      expose_top_q              <= 1'b0;
      expose_bot_q              <= 1'b0;
      shutter_top_q             <= 1'b0;
      shutter_bot_q             <= 1'b0;
      global_exposure_q         <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trigger_in;
      // Fractional accumulator keeps the average line period exact
      acc_q <= tick_d ? (acc_q + `CLK_PERIOD_PS10 - line_run)
                      : (acc_q + `CLK_PERIOD_PS10); // R17
      line_tick_q <= tick_d;

      if (load)
      begin
        // Restart line timing: a switch to the shorter line period would
        // otherwise leave acc_q high and fire several ticks back to back
        acc_q              <= 22'h00_0000; // R17
        slow_q             <= slow_scan;
        done_seen_q        <= 2'b00;
        exposure_ready_q   <= 1'b0;
        exposure_clamped_q <= |clamp_hit;
        below_top_q        <= (clamped[0] <= full_min); // R11
      end
      else
      begin
        if (q_done[0])
          raw_top_q <= q_count[0]; // R7 R17
        if (q_done[1])
          raw_bot_q <= q_count[1];
        done_seen_q <= done_seen_q | q_done;
        if ((done_seen_q | q_done) == 2'b11)
          exposure_ready_q <= 1'b1;
      end

      exposure_line_count_top_q <= exp_top;
      exposure_line_count_bot_q <= exp_bot;
      frame_lines_q             <= frame_len;
      readout_start_q           <= 1'b0;

      case (state_q)
        S_IDLE:
        begin
          lc_q <= 21'h00_0000;
          // Free run starts at once; the other modes wait for a rising edge
          if (run_en && exposure_ready_q && (m_free || trig_rise))
          begin
            state_q         <= S_RUN;
            readout_start_q <= m_sync; // R3
          end
        end
        S_RUN:
        begin
          if (!run_en)
            state_q <= S_IDLE;
          else if (tick_d)
          begin
            if (last_line)
            begin
              lc_q <= 21'h00_0000;
              // Triggered frames end here; edges seen during them are lost
              if (!(m_free || m_start))
                state_q <= S_IDLE;
              else
                readout_start_q <= 1'b1; // R1 R4
            end
            else
            begin
              lc_q <= lc_q + 21'h00_0001;
              if (m_trig && (lc_q + 21'h00_0001 == ro_at))
                readout_start_q <= 1'b1; // R12
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase

      // Both windows close at ro_at, so the shorter one opens later
      expose_top_q <= idle_x ||
                      (pre_ro && remain <= {1'b0, exp_top}); // R12
      expose_bot_q <= idle_x ||
                      (pre_ro && remain <= {1'b0, exp_bot}); // R12 R6
      shutter_top_q <= (m_free || m_start) &&
                       ((exp_top < exp_bot) || both_short); // R13
      shutter_bot_q <= (m_free || m_start) &&
                       ((exp_bot < exp_top) || both_short); // R13
      global_exposure_q <= !both_short &&
                           (gexp_follow_short ? g_short : g_long); // R15 R16
    end
  end

endmodule

// ### tb/exposure_timing_assertions.sv
`timescale 1ns/1ps
`include "exposure_timing_defs.vh"
module exposure_timing_checker
(
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Watched ports
  input wire        slow_scan,
  input wire [2:0]  trigger_mode,
  input wire [10:0] vertical_line_count,
  input wire        load,
  input wire        exposure_ready_q,
  input wire [19:0] exposure_line_count_top_q,
  input wire [19:0] exposure_line_count_bot_q,
  input wire        line_tick_q,
  input wire        expose_top_q,
  input wire        expose_bot_q,
  input wire        shutter_top_q,
  input wire        shutter_bot_q,
  input wire        global_exposure_q
);
  reg  [11:0] gap_q;
  reg  [5:0]  ld_q;
  reg         seen_q;
  wire        shared = trigger_mode == `MODE_LEVEL ||
    trigger_mode == `MODE_SYNC || trigger_mode == `MODE_GR_LEVEL;
  wire        both_short = exposure_line_count_top_q < vertical_line_count
    && exposure_line_count_bot_q < vertical_line_count;
  // Spacing not trusted until the scan rate settles after a load
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gap_q  <= 12'h000;
      ld_q   <= 6'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= line_tick_q ? 12'h001 : gap_q + {11'h000, gap_q != 12'hFFF};
      ld_q   <= load ? 6'h01 : ld_q + {5'h00, ld_q != 6'h00};
      seen_q <= (line_tick_q || seen_q) && ld_q == 6'h00 && !load;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_shared_ready;
    $rose(exposure_ready_q) && shared;
  endsequence
  sequence s_split_end;
    $past(expose_top_q) && $past(expose_bot_q) && !(expose_top_q && expose_bot_q);
  endsequence
  property p_tick_gap;
    line_tick_q && seen_q |-> (slow_scan && gap_q inside {[1299:1300]}) ||
      (!slow_scan && gap_q inside {[389:390]});
  endproperty
  property p_tick_pulse;
    line_tick_q |=> !line_tick_q;
  endproperty
  property p_ready_lat;
    $rose(exposure_ready_q) |-> ld_q inside {[42:43]};
  endproperty
  property p_shared;
    s_shared_ready |=> exposure_line_count_top_q == exposure_line_count_bot_q;
  endproperty
  property p_end_together;
    s_split_end |-> !expose_top_q && !expose_bot_q;
  endproperty
  property p_global_off;
    $past(both_short) && both_short |-> !global_exposure_q;
  endproperty
  property p_global_in;
    global_exposure_q |-> expose_top_q || expose_bot_q;
  endproperty
  property p_shutter;
    shutter_top_q || shutter_bot_q |->
      $past(trigger_mode) inside {`MODE_FREE, `MODE_START};
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("line tick spacing wrong");
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("line tick longer than one cycle");
  a_ready_lat: assert property (p_ready_lat)
    else $error("ready latency wrong");
  a_shared: assert property (p_shared)
    else $error("shared exposure differs");
  a_end_together: assert property (p_end_together)
    else $error("halves end exposure apart");
  a_global_off: assert property (p_global_off)
    else $error("global pulse while both short");
  a_global_in: assert property (p_global_in)
    else $error("global pulse outside exposure");
  a_shutter: assert property (p_shutter)
    else $error("shutter in triggered mode");
endmodule
bind split_area_exposure_timing exposure_timing_checker i_checker (.*);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "exposure_timing_defs.vh"
module tb_top;
  // Stimulus
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        slow_scan = 1'b0;
  logic [2:0]  trigger_mode = 3'h0;
  logic [10:0] vertical_line_count = 11'h004;
  logic        subarray_en = 1'b0;
  logic [10:0] subarray_lines = 11'h004;
  logic        gexp_follow_short = 1'b0;
  logic        run_en = 1'b0;
  logic        load = 1'b0;
  logic [32:0] requested_exposure_top = 33'h0;
  logic [32:0] requested_exposure_bot = 33'h0;
  wire         trigger_in;
  // Observed
  wire         exposure_ready_q;
  wire         exposure_clamped_q;
  wire [19:0]  exposure_line_count_top_q;
  wire [19:0]  exposure_line_count_bot_q;
  wire [20:0]  frame_lines_q;
  wire         line_tick_q;
  wire         readout_start_q;
  wire         expose_top_q;
  wire         expose_bot_q;
  wire         shutter_top_q;
  wire         shutter_bot_q;
  wire         global_exposure_q;
  logic [63:0] exp_q[$];
  logic        rdy_prev = 1'b0;
  int          n_top, n_bot, n_gl, n_ro, gap, last_gap;
  int          fail_count = 0;
  int          n_compared = 0;
  event        measured;
  event        gapped;
  split_area_exposure_timing i_split_area_exposure_timing (.*);
  trigger_source i_trigger_source (.*);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got);
    logic [63:0] e;
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  function automatic longint lines_of(longint ns, bit s, output bit c);
    longint mn, mx, lp;
    mn = subarray_en ? (s ? `SUB_MIN_SLOW_NS : `SUB_MIN_STD_NS)
      * subarray_lines / 4 : (s ? `EXP_MIN_SLOW_NS : `EXP_MIN_STD_NS);
    mx = s ? `EXP_MAX_SLOW_NS : `EXP_MAX_STD_NS;
    lp = s ? `LINE_SLOW_PS10 : `LINE_STD_PS10;
    c = ns < mn || ns > mx;
    ns = ns < mn ? mn : (ns > mx ? mx : ns);
    return (ns * 100 + lp - 1) / lp;
  endfunction
  task automatic ld(bit s, sub, logic [2:0] m, int vn, longint t, b);
    bit ct, cb;
    longint lt, lb;
    @(negedge clk);
    slow_scan = s;
    subarray_en = sub;
    trigger_mode = m;
    vertical_line_count = vn[10:0];
    lt = lines_of(t, s, ct);
    lb = lines_of(b, s, cb);
    if (m == `MODE_LEVEL || m == `MODE_SYNC || m == `MODE_GR_LEVEL ||
        (m == `MODE_FREE && sub && t <= (s ? 3000000 : 1000000)))
      lb = lt;
    exp_q.push_back(lt);
    exp_q.push_back(lb);
    exp_q.push_back(ct | cb);
    if (m < 5)
      exp_q.push_back(m == `MODE_FREE || m == `MODE_START ? vn :
        m == `MODE_SYNC ? vn + 5 : vn + (lt > lb ? lt : lb) + 10);
    requested_exposure_top = t[32:0];
    requested_exposure_bot = b[32:0];
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    for (int i = 0; i < 60 && exposure_ready_q !== 1'b1; i++)
      @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge line_tick_q);
    @(negedge clk);
  endtask
  // Late second trigger must be ignored while the frame still runs
  task automatic frm(int vn, et, eb, eg);
    @(negedge clk);
    vertical_line_count = vn[10:0];
    run_en = 1'b1;
    {n_top, n_bot, n_gl, n_ro} = '0;
    i_trigger_source.fire();
    wt(vn + et + 7);
    i_trigger_source.fire();
    wt(8);
    exp_q.push_back(et);
    exp_q.push_back(eb);
    exp_q.push_back(eg);
    exp_q.push_back(1);
    -> measured;
    @(negedge clk);
    run_en = 1'b0;
  endtask
  task automatic frun(int vn, et, eb);
    @(negedge clk);
    run_en = 1'b1;
    wt(vn * 2 + 2);
    exp_q.push_back(vn);
    exp_q.push_back(et);
    exp_q.push_back(eb);
    -> gapped;
    @(negedge clk);
    run_en = 1'b0;
  endtask
  task automatic results();
    // Notes never consumed mean a result that never appeared
    if (exp_q.size() != 0)
      fail_count++;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (exposure_ready_q === 1'b1 && rdy_prev !== 1'b1)
    begin
      repeat (2) @(negedge clk);
      chk(exposure_line_count_top_q);
      chk(exposure_line_count_bot_q);
      chk(exposure_clamped_q);
      if (trigger_mode < 5)
        chk(frame_lines_q);
    end
    rdy_prev = exposure_ready_q;
  end
  always @(posedge clk)
  begin
    if (readout_start_q === 1'b1)
    begin
      last_gap = gap;
      gap = 0;
      n_ro++;
    end
    if (line_tick_q === 1'b1)
    begin
      gap++;
      n_top += expose_top_q;
      n_bot += expose_bot_q;
      n_gl += global_exposure_q;
    end
  end
  always @(measured)
  begin
    chk(n_top);
    chk(n_bot);
    chk(n_gl);
    chk(n_ro);
  end
  always @(gapped)
  begin
    chk(last_gap);
    chk(shutter_top_q);
    chk(shutter_bot_q);
  end
  initial
  begin
    #1800000;
    fail_count++;
    results();
  end
  initial
  begin
    void'($urandom(32'he0ac));
    repeat (4) @(negedge clk);
    reset = 1'b0;
    ld(0, 0, `MODE_FREE, 8, 500, 33'h0_B2D0_5E00);
    ld(1, 0, `MODE_EDGE, 8, 3000000, 33'h1_A13B_8600);
    ld(1, 0, `MODE_FREE, 16, 3000000, 3100000);
    repeat (2700) @(negedge clk);
    ld(1, 1, `MODE_SYNC, 8, 129990, 400000);
    ld(0, 1, `MODE_START, 4, 75000, 38960);
    subarray_lines = 11'h008;
    ld(0, 1, `MODE_LEVEL, 4, 77000, 100000);
    subarray_lines = 11'h004;
    ld(0, 1, `MODE_GR_LEVEL, 4, 60000, 40000);
    ld(0, 1, `MODE_GR_EDGE, 4, 60000, 40000);
    repeat (3)
      ld(0, 1, `MODE_EDGE, 4, 38960 + $urandom_range(160000),
         38960 + $urandom_range(160000));
    ld(0, 1, `MODE_EDGE, 4, 75000, 38960);
    frm(2, 8, 4, 6);
    gexp_follow_short = 1'b1;
    frm(2, 8, 4, 2);
    frm(10, 8, 4, 0);
    ld(0, 1, `MODE_FREE, 4, 1500000, 38960);
    frun(4, 0, 1);
    ld(0, 1, `MODE_FREE, 10, 75000, 38960);
    frun(10, 1, 1);
    results();
  end
endmodule

// ### tb/trigger_source.sv
`timescale 1ns/1ps
module trigger_source
(
  // Clock
  input  wire  clk,
  // Trigger line
  output logic trigger_in
);
  initial trigger_in = 1'b0;
  // Two cycles high so the rise is sampled cleanly
  task automatic fire();
    @(negedge clk);
    trigger_in = 1'b1;
    repeat (2) @(negedge clk);
    trigger_in = 1'b0;
  endtask
endmodule
